// *** verilog/selftest_dispatch.sv ***
// memory self-test dispatch with datalog capture, bitmap stall and address scramble
//
// How it works
// - any mix of array enables accepted
// - itcm and dtcm units may run together
// - out-of-bounds addresses gate the chip select
// - datalog captured at first miscompare only
// - datalog shifts out on serial bit zero
// - bitmap mode stalls controller on every read
// - passing bitmap read releases the controller
// - failing bitmap read raises fail flag bit two
// - bitmap failure stalls until datalog unloaded
// - shift strobe divides the test clock enable
// - strobe release clears datalog and releases controller
// - mask holds failing bits; pattern replicates expected
// - logged select is the driven chip select
// - bounds limits follow configured memory size
// - column bit zero becomes xor of bits
// - instruction completion clears per-array fail flags
// - log order: pattern, index, difference mask
`timescale 1ns/1ns
module selftest_dispatch
    import selftest_dispatch_pkg::*;
(
    input  wire logic                     sys_clk,
    input  wire logic                     resetn,
    input  wire logic [ENABLE_WIDTH-1:0]  test_instruction_enables,
    input  wire logic                     bitmap_mode,
    input  wire logic                     instruction_done,
    input  wire test_op_t                 test_op,
    input  wire logic [DATA_WIDTH-1:0]    itcm_read_data,
    input  wire logic [DATA_WIDTH-1:0]    dtcm_read_data,
    input  wire logic                     datalog_shift_strobe,
    input  wire logic                     test_clock_enable,
    output logic                          controller_stall,
    output logic                          shift_clock_enable,
    output logic [RESULT_WIDTH-1:0]       test_result_out,
    output logic                          test_serial_out_port,
    output logic [ENABLE_WIDTH-1:0]       array_fail_flags,
    output logic                          itcm_chip_select,
    output logic                          dtcm_chip_select,
    output logic [INDEX_WIDTH-1:0]        itcm_address,
    output logic [INDEX_WIDTH-1:0]        dtcm_address
);

    dispatch_state_t s_q;
    dispatch_state_t s_d;

    function automatic logic [YADDR_WIDTH-1:0] scramble_y(
        input logic [YADDR_WIDTH-1:0] y
    );
        logic [YADDR_WIDTH-1:0] r;
        r    = y;
        r[0] = y[1] ^ y[0];
        return r;
    endfunction

    function automatic logic out_of_bounds(
        input logic [YADDR_WIDTH-1:0] y,
        input logic [XADDR_WIDTH-1:0] x
    );
        return (y > TCM_Y_LIMIT) || (x > TCM_X_LIMIT);
    endfunction

    function automatic logic [INDEX_WIDTH-1:0] tcm_index(
        input logic [YADDR_WIDTH-1:0] y,
        input logic [XADDR_WIDTH-1:0] x
    );
        return {y[8:3], x[7:0], y[2:0]};
    endfunction

    logic [YADDR_WIDTH-1:0]  y_scr;
    logic                    outside;
    logic [1:0]              cs_vec;
    logic [YADDR_WIDTH-1:0]  pend_y;
    logic [DATA_WIDTH-1:0]   expect_word;
    logic [DATA_WIDTH-1:0]   read_word;
    logic [DATA_WIDTH-1:0]   diff;
    logic                    compare_now;
    logic                    miscompare;
    logic                    shifting;
    logic                    issue_wait;

    // both tcm units decode the same op; any enable mix is taken
    assign y_scr   = scramble_y(test_op.yaddr);
    assign outside = out_of_bounds(y_scr, test_op.xaddr);
    assign cs_vec[0] = test_op.valid & test_instruction_enables[ITCM_BIT] & ~outside;
    assign cs_vec[1] = test_op.valid & test_instruction_enables[DTCM_BIT] & ~outside;
    // a stalled bitmap read is issued once from the wait state
    assign issue_wait = (s_q.state == ST_WAIT) & ~s_q.pend.valid;
    assign itcm_chip_select = cs_vec[0] & ((~controller_stall & ~s_q.released) | issue_wait);
    assign dtcm_chip_select = cs_vec[1] & ((~controller_stall & ~s_q.released) | issue_wait);
    assign itcm_address = tcm_index(y_scr, test_op.xaddr);
    assign dtcm_address = tcm_index(y_scr, test_op.xaddr);

    // compare one cycle after the read is issued
    assign pend_y      = scramble_y(s_q.pend.yaddr);
    assign expect_word = {(DATA_WIDTH/PATTERN_WIDTH){s_q.pend.pattern}};
    assign read_word   = (s_q.logged_array_select[1] ? dtcm_read_data : '0)
                       | (s_q.logged_array_select[0] ? itcm_read_data : '0);
    assign diff        = read_word ^ expect_word;
    assign compare_now = s_q.pend.valid & s_q.pend.is_read & (|s_q.logged_array_select);
    assign miscompare  = compare_now & (|diff);
    assign shifting    = datalog_shift_strobe & test_clock_enable & (s_q.div == SHIFT_DIV_LAST);

    // stall while a bitmap read is unresolved or a failure is held
    assign controller_stall = (s_q.state != ST_RUN)
                            | (bitmap_mode & test_op.valid & test_op.is_read
                               & ~s_q.released);
    assign shift_clock_enable = datalog_shift_strobe ? shifting : test_clock_enable;
    assign test_result_out = {s_q.fail_out, 1'b0, s_q.serial_out};
    assign test_serial_out_port = s_q.serial_out;
    assign array_fail_flags = s_q.fail_flags;

    always_comb
    begin
        s_d = s_q;
        s_d.pend = test_op;
        s_d.released = 1'b0;
        // a released read was already compared; do not issue it again
        s_d.pend.valid = test_op.valid & ~controller_stall & ~s_q.released;
        if (test_op.valid && !controller_stall && !s_q.released)
        begin
            s_d.logged_array_select = cs_vec;
        end
        // a failure in the completion cycle survives the clear
        if (instruction_done)
        begin
            s_d.fail_flags = ENABLE_RESET;
        end
        if (miscompare)
        begin
            s_d.fail_flags[ITCM_BIT] = s_d.fail_flags[ITCM_BIT] | s_q.logged_array_select[0];
            s_d.fail_flags[DTCM_BIT] = s_d.fail_flags[DTCM_BIT] | s_q.logged_array_select[1];
            if (!s_q.logged)
            begin
                s_d.logged = 1'b1;
                s_d.log.expected_pattern = s_q.pend.pattern;
                s_d.log.failing_index    = tcm_index(pend_y, s_q.pend.xaddr);
                s_d.log.failing_bit_mask = diff;
                s_d.serial_out = diff[0];
            end
            if (bitmap_mode)
            begin
                s_d.fail_out = 1'b1;
            end
        end
        if (datalog_shift_strobe)
        begin
            if (test_clock_enable)
            begin
                s_d.div = s_q.div + 1'b1;
            end
            s_d.shift_seen = 1'b1;
        end
        if (shifting)
        begin
            s_d.log = datalog_t'({1'b0, s_q.log[LOG_WIDTH-1:1]});
            s_d.serial_out = s_q.log[1];
        end
        unique case (s_q.state)
            ST_RUN:
            begin
                if (bitmap_mode && test_op.valid && test_op.is_read && !s_q.released)
                begin
                    s_d.state = ST_WAIT;
                end
            end
            ST_WAIT:
            begin
                s_d.pend.valid = 1'b0;
                if (s_q.pend.valid)
                begin
                    s_d.state = miscompare ? ST_FAIL_HOLD : ST_RUN;
                    s_d.released = ~miscompare;
                end
                else
                begin
                    s_d.pend = s_q.pend;
                    s_d.pend.valid = 1'b1;
                    s_d.logged_array_select = cs_vec;
                end
            end
            ST_FAIL_HOLD:
            begin
                s_d.pend.valid = 1'b0;
            end
        endcase
        if (s_q.shift_seen && !datalog_shift_strobe)
        begin
            s_d.log        = LOG_RESET;
            s_d.logged     = 1'b0;
            s_d.fail_out   = 1'b0;
            s_d.serial_out = 1'b0;
            s_d.div        = '0;
            s_d.shift_seen = 1'b0;
            s_d.state      = ST_RUN;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s_q <= '{state: ST_RUN, log: LOG_RESET, fail_flags: ENABLE_RESET,
                     pend: '0, div: '0, logged_array_select: 2'h0, default: 1'b0};
        end
        else
        begin
            s_q <= s_d;
        end
    end

endmodule

// *** verilog/selftest_dispatch_pkg.sv ***
// shared types and constants for the memory self-test dispatch block
package selftest_dispatch_pkg;

    localparam int ENABLE_WIDTH  = 16;
    localparam int XADDR_WIDTH   = 11;
    localparam int YADDR_WIDTH   = 12;
    localparam int DATA_WIDTH    = 64;
    localparam int INDEX_WIDTH   = 17;
    localparam int PATTERN_WIDTH = 4;
    localparam int LOG_WIDTH     = PATTERN_WIDTH + INDEX_WIDTH + DATA_WIDTH;
    localparam int RESULT_WIDTH  = 3;
    localparam int FAIL_FLAG_BIT = 2;
    localparam int SHIFT_BIT     = 0;

    // array enable positions
    localparam int ITCM_BIT = 8;
    localparam int DTCM_BIT = 9;

    // out-of-bounds limits from the configured tcm size
    localparam logic [YADDR_WIDTH-1:0] TCM_Y_LIMIT = 12'h1ff;
    localparam logic [XADDR_WIDTH-1:0] TCM_X_LIMIT = 11'h0ff;

    // serial shift divider while the datalog is unloaded
    localparam int                    SHIFT_DIV_BITS  = 2;
    localparam logic [SHIFT_DIV_BITS-1:0] SHIFT_DIV_LAST = 2'h3;

    localparam logic [LOG_WIDTH-1:0]    LOG_RESET    = '0;
    localparam logic [ENABLE_WIDTH-1:0] ENABLE_RESET = '0;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_WAIT,
        ST_FAIL_HOLD
    } stall_state_t;

    typedef struct packed {
        logic                     valid;
        logic                     is_read;
        logic [XADDR_WIDTH-1:0]   xaddr;
        logic [YADDR_WIDTH-1:0]   yaddr;
        logic [PATTERN_WIDTH-1:0] pattern;
    } test_op_t;

    typedef struct packed {
        logic [PATTERN_WIDTH-1:0] expected_pattern;
        logic [INDEX_WIDTH-1:0]   failing_index;
        logic [DATA_WIDTH-1:0]    failing_bit_mask;
    } datalog_t;

    typedef struct packed {
        stall_state_t              state;
        logic                      logged;
        datalog_t                  log;
        logic [1:0]                logged_array_select;
        logic [ENABLE_WIDTH-1:0]   fail_flags;
        logic                      fail_out;
        logic                      serial_out;
        logic [SHIFT_DIV_BITS-1:0] div;
        logic                      shift_seen;
        logic                      released;
        test_op_t                  pend;
    } dispatch_state_t;

endpackage

// *** sim/selftest_dispatch_properties.sv ***
// port assertions for the self-test dispatch block
`timescale 1ns/1ns
module selftest_dispatch_properties
    import selftest_dispatch_pkg::*;
(
    input wire logic                    sys_clk,
    input wire logic                    resetn,
    input wire logic [ENABLE_WIDTH-1:0] test_instruction_enables,
    input wire logic                    bitmap_mode,
    input wire test_op_t                test_op,
    input wire logic                    datalog_shift_strobe,
    input wire logic                    test_clock_enable,
    input wire logic                    controller_stall,
    input wire logic                    shift_clock_enable,
    input wire logic [RESULT_WIDTH-1:0] test_result_out,
    input wire logic                    test_serial_out_port,
    input wire logic                    itcm_chip_select,
    input wire logic [INDEX_WIDTH-1:0]  itcm_address
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    chk_serial_mirror: assert property (test_result_out[0] == test_serial_out_port)
        else $error("serial port differs from result bit zero");
    chk_read_stalled: assert property (bitmap_mode && test_op.valid && test_op.is_read
        && !controller_stall |-> $past(controller_stall))
        else $error("bitmap read taken without a stall");
    chk_fail_raise: assert property ($rose(test_result_out[FAIL_FLAG_BIT])
        |-> bitmap_mode && controller_stall)
        else $error("fail flag rose outside a stalled bitmap read");
    chk_fail_holds: assert property (test_result_out[FAIL_FLAG_BIT] && datalog_shift_strobe
        |=> test_result_out[FAIL_FLAG_BIT] && controller_stall)
        else $error("fail hold left before unload ended");
    chk_release_clears: assert property ($fell(datalog_shift_strobe)
        |-> ##[0:2] (!test_result_out[FAIL_FLAG_BIT] && !controller_stall))
        else $error("strobe release did not clear fail and stall");
    chk_clken_follow: assert property (!datalog_shift_strobe
        |-> shift_clock_enable == test_clock_enable)
        else $error("clock enable not passed through");
    chk_clken_divide: assert property (datalog_shift_strobe && shift_clock_enable
        ##1 datalog_shift_strobe |-> !shift_clock_enable)
        else $error("clock enable not divided during unload");
    chk_oob_gate: assert property (itcm_chip_select
        |-> test_op.yaddr[11:9] == 3'h0 && test_op.xaddr[10:8] == 3'h0)
        else $error("chip select beyond array bounds");
    chk_cs_enable: assert property (itcm_chip_select
        |-> test_instruction_enables[ITCM_BIT])
        else $error("chip select without array enable");
    chk_addr_scramble: assert property (itcm_chip_select |-> itcm_address == {test_op.yaddr[8:3],
        test_op.xaddr[7:0], test_op.yaddr[2:1], test_op.yaddr[1] ^ test_op.yaddr[0]})
        else $error("scrambled address mismatch");
    cover property (bitmap_mode && controller_stall ##1 !controller_stall);
    cover property ($rose(test_result_out[FAIL_FLAG_BIT]));
    cover property ($fell(datalog_shift_strobe));
endmodule
bind selftest_dispatch selftest_dispatch_properties selftest_dispatch_properties_inst (
    .sys_clk, .resetn, .test_instruction_enables, .bitmap_mode, .test_op,
    .datalog_shift_strobe, .test_clock_enable, .controller_stall, .shift_clock_enable,
    .test_result_out, .test_serial_out_port, .itcm_chip_select, .itcm_address);

// *** sim/selftest_array_model.sv ***
// tcm array model answering the dispatch block's chip selects
`timescale 1ns/1ns
module selftest_array_model
    import selftest_dispatch_pkg::*;
(
    input  wire logic                  sys_clk,
    input  wire logic                  itcm_chip_select,
    input  wire logic                  dtcm_chip_select,
    input  wire test_op_t              test_op,
    input  wire logic [DATA_WIDTH-1:0] flip,
    output logic [DATA_WIDTH-1:0]      itcm_read_data = '0,
    output logic [DATA_WIDTH-1:0]      dtcm_read_data = '0
);
    // unselected arrays toggle instead of holding the last word
    always @(posedge sys_clk)
    begin
        itcm_read_data <= itcm_chip_select ? {16{test_op.pattern}} ^ flip : ~itcm_read_data;
        dtcm_read_data <= dtcm_chip_select ? {16{test_op.pattern}} : ~dtcm_read_data;
    end
endmodule

// *** sim/test_selftest_dispatch.sv ***
// self-checking bench for the self-test dispatch block
`timescale 1ns/1ns
module test_selftest_dispatch;
    import selftest_dispatch_pkg::*;
    logic                    sys_clk, resetn, bitmap_mode, instruction_done;
    logic                    datalog_shift_strobe, test_clock_enable, stall, sce, serial;
    logic                    ics, dcs;
    logic [ENABLE_WIDTH-1:0] enables, fail_flags;
    logic [DATA_WIDTH-1:0]   flip, itcm_rd, dtcm_rd;
    logic [INDEX_WIDTH-1:0]  iaddr, daddr;
    logic [RESULT_WIDTH-1:0] result;
    test_op_t                test_op;
    int                      error_cnt = 0;
    int                      check_count = 0;
    selftest_dispatch selftest_dispatch_inst (.sys_clk, .resetn,
        .test_instruction_enables(enables), .bitmap_mode, .instruction_done, .test_op,
        .itcm_read_data(itcm_rd), .dtcm_read_data(dtcm_rd), .datalog_shift_strobe,
        .test_clock_enable, .controller_stall(stall), .shift_clock_enable(sce),
        .test_result_out(result), .test_serial_out_port(serial), .array_fail_flags(fail_flags),
        .itcm_chip_select(ics), .dtcm_chip_select(dcs), .itcm_address(iaddr),
        .dtcm_address(daddr));
    selftest_array_model selftest_array_model_inst (.sys_clk, .itcm_chip_select(ics),
        .dtcm_chip_select(dcs), .test_op, .flip, .itcm_read_data(itcm_rd),
        .dtcm_read_data(dtcm_rd));
    task automatic check_val(input logic [LOG_WIDTH-1:0] got, input logic [LOG_WIDTH-1:0] exp);
        check_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic summarize;
        if (error_cnt == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    function automatic logic [16:0] scr(input logic [10:0] x, input logic [11:0] y);
        return {y[8:3], x[7:0], y[2:1], y[1] ^ y[0]};
    endfunction
    task automatic set_op(input logic v, input logic [10:0] x, input logic [11:0] y);
        @(posedge sys_clk);
        test_op <= {v, 1'b1, x, y, 4'h5};
    endtask
    task automatic s_parallel;
        enables <= 16'h03ff;
        set_op(1'b1, 11'h0a5, 12'h1e6);
        @(negedge sys_clk);
        check_val({ics, dcs, iaddr, daddr},
                  {2'b11, scr(11'h0a5, 12'h1e6), scr(11'h0a5, 12'h1e6)});
        set_op(1'b1, 11'h0a5, 12'h200);
        @(negedge sys_clk);
        check_val({ics, dcs}, 2'b00);
        set_op(1'b1, 11'h100, 12'h1e6);
        @(negedge sys_clk);
        check_val({ics, dcs}, 2'b00);
        set_op(1'b0, 11'h0, 12'h0);
    endtask
    task automatic s_bitmap;
        int                     n = 0;
        logic [LOG_WIDTH-1:0]   log = '0;
        bitmap_mode <= 1'b1;
        enables <= 16'h0100;
        set_op(1'b1, 11'h033, 12'h0c9);
        @(negedge sys_clk);
        check_val(stall, 1'b1);
        for (int i = 0; i < 10 && stall; i++)
            @(negedge sys_clk);
        check_val({stall, result[FAIL_FLAG_BIT]}, 2'b00);
        flip <= 64'h8000_0000_0000_0001;
        set_op(1'b1, 11'h07e, 12'h1b2);
        repeat (5) @(negedge sys_clk);
        check_val({result[FAIL_FLAG_BIT], stall, fail_flags[ITCM_BIT]}, 3'h7);
        @(posedge sys_clk);
        datalog_shift_strobe <= 1'b1;
        for (int i = 0; i < 400 && n < LOG_WIDTH; i++)
        begin
            @(negedge sys_clk);
            if (sce === 1'b1)
            begin
                log[n] = serial;
                n++;
            end
        end
        check_val(log, {4'h5, scr(11'h07e, 12'h1b2), flip});
        check_val({stall, result[FAIL_FLAG_BIT]}, 2'b11);
        @(posedge sys_clk);
        datalog_shift_strobe <= 1'b0;
        test_op.valid <= 1'b0;
        repeat (3) @(negedge sys_clk);
        check_val({stall, result}, '0);
        @(posedge sys_clk);
        instruction_done <= 1'b1;
        @(posedge sys_clk);
        instruction_done <= 1'b0;
        @(negedge sys_clk);
        check_val(fail_flags, '0);
    endtask
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial
    begin
        #200000;
        error_cnt++;
        summarize;
    end
    initial
    begin
        {resetn, bitmap_mode, instruction_done, datalog_shift_strobe} = 4'h0;
        test_clock_enable = 1'b1;
        enables = ENABLE_RESET;
        flip = '0;
        test_op = '0;
        repeat (3) @(posedge sys_clk);
        resetn <= 1'b1;
        @(negedge sys_clk);
        check_val({stall, result, fail_flags}, '0);
        s_parallel;
        s_bitmap;
        summarize;
    end
endmodule
